// ==== design/ccsr_fast_shadow.sv ====
// One-deep shadow of ALU flags and working registers for fast save
module ccsr_fast_shadow (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Save request and live values
   input wire logic save,
   input wire ccsr_pkg::ccsr_alu_s alu_in,
   input wire ccsr_pkg::ccsr_wset_t w_in,
   // Held copies
   output ccsr_pkg::ccsr_alu_s alu_q,
   output ccsr_pkg::ccsr_wset_t w_q
);
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         alu_q <= '0;
         w_q <= '0;
      end else if (save) begin
         alu_q <= alu_in;
         w_q <= w_in;
      end
   end

   property p_save_hold;
      @(posedge sys_clk) disable iff (!resetn)
      save |=> (w_q == $past(w_in)) && (alu_q == $past(alu_in));
   endproperty
   a_save_hold: assert property (p_save_hold)
      else $error("fast save did not capture values");
endmodule : ccsr_fast_shadow

// ==== design/ccsr_loop_shadow.sv ====
// Hardware loop context with one-deep shadow and nesting depth
`include "ccsr_params.svh"
module ccsr_loop_shadow (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Loop events
   input wire logic push,
   input wire logic pop,
   input wire ccsr_pkg::ccsr_loop_s ctx_in,
   // Context and depth
   output ccsr_pkg::ccsr_loop_s ctx_q,
   output logic [2:0] depth_q
);
   ccsr_pkg::ccsr_loop_s shadow_q;
   wire nested = (depth_q != 3'h0);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctx_q <= '0;
         shadow_q <= '0;
         depth_q <= 3'h0;
      end else if (push) begin
         if (nested) shadow_q <= ctx_q;
         ctx_q <= ctx_in;
         if (depth_q != `CCSR_DEPTH_MAX) depth_q <= depth_q + 3'h1;
      end else if (pop && nested) begin
         if (depth_q != 3'h1) ctx_q <= shadow_q;
         depth_q <= depth_q - 3'h1;
      end
   end

   property p_shadow_copy;
      @(posedge sys_clk) disable iff (!resetn)
      push && nested |=> shadow_q == $past(ctx_q);
   endproperty
   a_shadow_copy: assert property (p_shadow_copy)
      else $error("loop shadow missed current context");
endmodule : ccsr_loop_shadow

// ==== design/ccsr_params.svh ====
// Offsets, field positions and the configuration reset value of the mode and flag registers
`ifndef CCSR_PARAMS_SVH
`define CCSR_PARAMS_SVH
// ***********************************************
// Register byte offsets
// ***********************************************
`define CCSR_FLAGS_OFS 4'h0
`define CCSR_CFG_OFS 4'h4
// ***********************************************
// Configuration register
// ***********************************************
`define CCSR_CFG_RST 16'h0020
`define CCSR_CFG_WMASK 16'h10F7
`define CCSR_CFG_ESTOP 11
`define CCSR_CFG_TRAP 3
`define CCSR_DEPTH_MAX 3'h7
// ***********************************************
// Flags register
// ***********************************************
`define CCSR_FL_SA 13
`define CCSR_FL_SB 12
`define CCSR_FL_SAB 10
`define CCSR_FL_DC 8
`define CCSR_FL_PRI_HI 7
`define CCSR_FL_PRI_LO 5
`define CCSR_FL_N 3
`define CCSR_FL_OV 2
`define CCSR_FL_Z 1
`define CCSR_FL_C 0
`endif

// ==== design/ccsr_pkg.sv ====
// Types shared by the mode and flag register block
package ccsr_pkg;
   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic dc;
      logic n;
      logic ov;
      logic z;
      logic c;
   } ccsr_alu_s;

   typedef struct packed {
      logic [15:0] count;
      logic [23:0] first;
      logic [23:0] last;
   } ccsr_loop_s;

   typedef struct packed {
      logic upd;
      logic spill;
      logic clamp;
   } ccsr_dsp_s;

   typedef logic [3:0][15:0] ccsr_wset_t;

   // Bus slave states
   typedef enum logic {CCSR_IDLE, CCSR_ANS} ccsr_bus_e;
endpackage : ccsr_pkg

// ==== design/ccsr_top.sv ====
// Core mode and flag registers with Avalon-MM slave and shadows
// What this block does
// - Reset loads configuration with 0x0020, only store clamping set.
// - Nested loop start copies current count, first and last address to one shadow.
// - Fast save shadows DC,N,OV,Z,C and W0-W3; restore returns them.
// - Shadow copies hold one entry and have no register address.
// - Configuration bits 10:8 report loop nesting depth, zero idle.
// - Writing one to bit 11 stops loop after iteration; reads zero.
// - Bits 7 and 6 enable clamping of accumulators A and B.
// - Bit 5 enables store clamping; resets to one.
// - Bit 4 picks normal 1.31 or super 9.31 clamping width.
// - Bit 3 reads one while a hardware trap is handled.
// - Priority is trap bit above flags bits 7 to 5.
// - Bit 2 maps program memory into data space; reset off.
// - Bit 1 picks biased rounding; zero picks convergent.
// - Bit 0 picks integer multiply; zero picks fractional.
// - Bit 12 picks unsigned multiply operands; reset signed.
// - Flags bit 4 shows a repeat in progress.
// - Flag ops set N, OV, Z from result, clear otherwise.
// - Flags bit 0 holds carry out, borrow for subtraction.
// - Accumulator clamped flags stay set until software clears.
// - Combined spill and clamped flags are ORs; clearing bit 10 clears both clamped flags.
// - Loop active flag is read only.
`include "ccsr_params.svh"
module ccsr_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // ALU flag update
   input wire logic flag_upd,
   input wire ccsr_pkg::ccsr_alu_s flag_in,
   // DSP accumulator status
   input wire ccsr_pkg::ccsr_dsp_s dsp_a,
   input wire ccsr_pkg::ccsr_dsp_s dsp_b,
   // Repeat tracking
   input wire logic repeat_start,
   input wire logic repeat_done,
   // Hardware loop
   input wire logic loop_start,
   input wire logic loop_end,
   input wire ccsr_pkg::ccsr_loop_s loop_in,
   // Exception priority
   input wire logic pri_load,
   input wire logic [2:0] pri_in,
   input wire logic trap_set,
   input wire logic trap_clr,
   // Fast save and restore
   input wire logic fast_save,
   input wire logic fast_restore,
   input wire ccsr_pkg::ccsr_wset_t w_live,
   // Loop context out
   output ccsr_pkg::ccsr_loop_s loop_ctx,
   output logic loop_early_stop,
   // Restored working registers
   output ccsr_pkg::ccsr_wset_t w_restore,
   output logic w_restore_valid,
   // Mode outputs
   output logic prog_window_enable,
   output logic acc_a_clamp_enable,
   output logic acc_b_clamp_enable,
   output logic store_clamp_enable,
   output logic acc_clamp_width_select,
   output logic round_bias_select,
   output logic mult_int_select,
   output logic mult_sign_select,
   // Status outputs
   output logic [3:0] cpu_priority,
   output ccsr_pkg::ccsr_alu_s alu_flags,
   output logic loop_active_flag,
   output logic repeat_active_flag,
   output logic [15:0] cpu_flags_register,
   output logic [15:0] core_configuration_register
);
   // ***********************************************
   // Helpers
   // ***********************************************
   // Byte-lane merge of a 16-bit write
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      merge16 = (old & ~m) | (nw & m);
   endfunction : merge16

   // ***********************************************
   // State
   // ***********************************************
   ccsr_pkg::ccsr_bus_e bus_q, bus_d;
   logic [31:0] rd_q;
   logic [15:0] cfg_q, cfg_d;
   ccsr_pkg::ccsr_alu_s alu_q, alu_d;
   logic [2:0] pri_q, pri_d;
   logic trap_q, trap_d;
   logic ra_q, ra_d;
   logic oa_q, oa_d, ob_q, ob_d;
   logic sa_q, sa_d, sb_q, sb_d;
   logic estop_q, estop_d;
   logic wrv_q;
   logic [2:0] depth;
   ccsr_pkg::ccsr_alu_s sh_alu;

   // ***********************************************
   // Bus decode
   // ***********************************************
   wire req = avs_read | avs_write;
   wire idle = (bus_q == ccsr_pkg::CCSR_IDLE);
   wire sel_fl = (avs_address == `CCSR_FLAGS_OFS);
   wire sel_cfg = (avs_address == `CCSR_CFG_OFS);
   wire commit = avs_write & ~idle;
   wire fl_wr = commit & sel_fl;
   wire cfg_wr = commit & sel_cfg;
   wire [15:0] wdat = avs_writedata[15:0];
   wire [1:0] be = avs_byteenable[1:0];
   wire [15:0] fl_new = merge16(cpu_flags_register, wdat, be);
   wire [15:0] cfg_new = merge16(cfg_q, wdat, be);

   // Answer one cycle after the request is seen
   assign avs_waitrequest = req & idle;
   assign avs_readdata = rd_q;

   // Bus state sequence
   always_comb begin
      case (bus_q)
         ccsr_pkg::CCSR_IDLE: bus_d = req ? ccsr_pkg::CCSR_ANS : bus_q;
         ccsr_pkg::CCSR_ANS: bus_d = ccsr_pkg::CCSR_IDLE;
         default: bus_d = ccsr_pkg::CCSR_IDLE;
      endcase
   end

   // ***********************************************
   // Register words
   // ***********************************************
   // compose configuration readback
   assign core_configuration_register = {3'h0, cfg_q[12], 1'b0, depth,
                                         cfg_q[7:4], trap_q, cfg_q[2:0]};
   assign cpu_flags_register = {oa_q, ob_q, sa_q, sb_q, oa_q | ob_q,
                                sa_q | sb_q, loop_active_flag, alu_q.dc,
                                pri_q, ra_q, alu_q.n, alu_q.ov, alu_q.z,
                                alu_q.c};

   // ***********************************************
   // Next values
   // ***********************************************
   // writable mode bits only
   assign cfg_d = cfg_wr ? (cfg_new & `CCSR_CFG_WMASK) : cfg_q;

   always_comb begin
      alu_d = alu_q;
      if (fl_wr) begin
         alu_d.dc = fl_new[`CCSR_FL_DC];
         alu_d.n = fl_new[`CCSR_FL_N];
         alu_d.ov = fl_new[`CCSR_FL_OV];
         alu_d.z = fl_new[`CCSR_FL_Z];
         alu_d.c = fl_new[`CCSR_FL_C];
      end
      if (flag_upd) alu_d = flag_in;
      if (fast_restore) alu_d = sh_alu;
   end

   // pipeline priority load over software write
   assign pri_d = pri_load ? pri_in :
                  fl_wr ? fl_new[`CCSR_FL_PRI_HI:`CCSR_FL_PRI_LO] : pri_q;

   wire trap_wclr = cfg_wr & be[0] & ~wdat[`CCSR_CFG_TRAP];
   assign trap_d = trap_set | (trap_q & ~trap_clr & ~trap_wclr);

   assign ra_d = repeat_start | (ra_q & ~repeat_done);

   // Guard spill follows the latest DSP result
   assign oa_d = dsp_a.upd ? dsp_a.spill : oa_q;
   assign ob_d = dsp_b.upd ? dsp_b.spill : ob_q;

   // sticky clamp flags, set beats clear
   wire sab_clr = fl_wr & be[1] & ~wdat[`CCSR_FL_SAB];
   wire sa_clr = sab_clr | (fl_wr & be[1] & ~wdat[`CCSR_FL_SA]);
   wire sb_clr = sab_clr | (fl_wr & be[1] & ~wdat[`CCSR_FL_SB]);
   wire sa_set = dsp_a.upd & dsp_a.clamp;
   wire sb_set = dsp_b.upd & dsp_b.clamp;
   assign sa_d = sa_set | (sa_q & ~sa_clr);
   assign sb_d = sb_set | (sb_q & ~sb_clr);

   // early stop request held until the loop ends
   wire estop_set = cfg_wr & be[1] & wdat[`CCSR_CFG_ESTOP] & loop_active_flag;
   assign estop_d = loop_end ? 1'b0 : (estop_q | estop_set);

   // ***********************************************
   // Registers
   // ***********************************************
   // reset values
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bus_q <= ccsr_pkg::CCSR_IDLE;
         cfg_q <= `CCSR_CFG_RST;
         alu_q <= '0;
         pri_q <= 3'h0;
         trap_q <= 1'b0;
         ra_q <= 1'b0;
      end else begin
         bus_q <= bus_d;
         cfg_q <= cfg_d;
         alu_q <= alu_d;
         pri_q <= pri_d;
         trap_q <= trap_d;
         ra_q <= ra_d;
      end
   end

   // Accumulator status and loop stop
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         oa_q <= 1'b0;
         ob_q <= 1'b0;
         sa_q <= 1'b0;
         sb_q <= 1'b0;
         estop_q <= 1'b0;
         wrv_q <= 1'b0;
      end else begin
         oa_q <= oa_d;
         ob_q <= ob_d;
         sa_q <= sa_d;
         sb_q <= sb_d;
         estop_q <= estop_d;
         wrv_q <= fast_restore;
      end
   end

   // Read data captured as the request is seen; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rd_q <= 32'h0000_0000;
      end else if (avs_read & idle) begin
         rd_q <= sel_fl ? {16'h0000, cpu_flags_register} :
                 sel_cfg ? {16'h0000, core_configuration_register} :
                 32'h0000_0000;
      end
   end

   // ***********************************************
   // Shadows
   // ***********************************************
   // loop context, no bus path
   ccsr_loop_shadow u_loop (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .push(loop_start),
      .pop(loop_end),
      .ctx_in(loop_in),
      .ctx_q(loop_ctx),
      .depth_q(depth)
   );

   // fast save copies, no bus path
   ccsr_fast_shadow u_fast (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .save(fast_save),
      .alu_in(alu_q),
      .w_in(w_live),
      .alu_q(sh_alu),
      .w_q(w_restore)
   );

   // ***********************************************
   // Outputs
   // ***********************************************
   // loop active derived from depth only
   assign loop_active_flag = (depth != 3'h0);
   assign loop_early_stop = estop_q;
   assign w_restore_valid = wrv_q;
   assign repeat_active_flag = ra_q;
   assign alu_flags = alu_q;
   assign cpu_priority = {trap_q, pri_q};
   assign acc_a_clamp_enable = cfg_q[7];
   assign acc_b_clamp_enable = cfg_q[6];
   assign store_clamp_enable = cfg_q[5];
   assign acc_clamp_width_select = cfg_q[4];
   assign prog_window_enable = cfg_q[2];
   assign round_bias_select = cfg_q[1];
   assign mult_int_select = cfg_q[0];
   assign mult_sign_select = cfg_q[12];

   // ***********************************************
   // Checks
   // ***********************************************
   sequence s_req_seen;
      req && idle;
   endsequence
   sequence s_answer;
      !avs_waitrequest;
   endsequence

   property p_bus_answer;
      @(posedge sys_clk) disable iff (!resetn)
      s_req_seen |-> avs_waitrequest ##1 s_answer;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not one cycle late");

   property p_rst_cfg;
      @(posedge sys_clk) !resetn |=> core_configuration_register == 16'h0020;
   endproperty
   a_rst_cfg: assert property (p_rst_cfg)
      else $error("configuration reset value wrong");

   property p_cfg_zero;
      @(posedge sys_clk) disable iff (!resetn)
      core_configuration_register[15:13] == 3'h0 &&
      !core_configuration_register[11];
   endproperty
   a_cfg_zero: assert property (p_cfg_zero)
      else $error("unimplemented or stop bit reads nonzero");

   property p_depth;
      @(posedge sys_clk) disable iff (!resetn)
      loop_start && depth == 3'h0 |=>
         core_configuration_register[10:8] == 3'h1 && cpu_flags_register[9];
   endproperty
   a_depth: assert property (p_depth)
      else $error("loop depth not reported");

   property p_estop;
      @(posedge sys_clk) disable iff (!resetn)
      estop_set && !loop_end |=> loop_early_stop [*1] ##1
         (loop_early_stop || $past(loop_end));
   endproperty
   a_estop: assert property (p_estop)
      else $error("early stop not held");

   property p_sticky;
      @(posedge sys_clk) disable iff (!resetn)
      sa_q && !fl_wr |=> sa_q;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("clamp flag dropped without clear");

   property p_set_wins;
      @(posedge sys_clk) disable iff (!resetn)
      sb_set |=> cpu_flags_register[12] && cpu_flags_register[10];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clamp event lost");

   property p_trap;
      @(posedge sys_clk) disable iff (!resetn)
      trap_set |=> cpu_priority[3] && core_configuration_register[3];
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap priority not raised");

   property p_alu;
      @(posedge sys_clk) disable iff (!resetn)
      flag_upd && !fast_restore |=> alu_flags == $past(flag_in);
   endproperty
   a_alu: assert property (p_alu)
      else $error("ALU flags not updated");

   property p_repeat;
      @(posedge sys_clk) disable iff (!resetn)
      repeat_done && !repeat_start |=> !repeat_active_flag;
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("repeat flag not cleared");
endmodule : ccsr_top

// ==== dv/ccsr_pipe_model.sv ====
// Execution pipeline stand-in that drives the event side of the block
module ccsr_pipe_model (
   // Clock
   input wire logic sys_clk,
   // Strobes
   output logic flag_upd,
   output logic repeat_start,
   output logic repeat_done,
   output logic loop_start,
   output logic loop_end,
   output logic pri_load,
   output logic trap_set,
   output logic trap_clr,
   output logic fast_save,
   output logic fast_restore,
   // Data carried with the strobes
   output ccsr_pkg::ccsr_alu_s flag_in,
   output ccsr_pkg::ccsr_dsp_s dsp_a,
   output ccsr_pkg::ccsr_dsp_s dsp_b,
   output ccsr_pkg::ccsr_loop_s loop_in,
   output logic [2:0] pri_in,
   output ccsr_pkg::ccsr_wset_t w_live
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] ev = '0;
   logic [75:0] dat = '0;
   // Strobe lines, one bit each
   assign {fast_restore, fast_save, trap_clr, trap_set, pri_load, loop_end,
      loop_start, repeat_done, repeat_start, flag_upd} = ev[9:0];
   // Data fields; junk outside a strobe
   assign loop_in = dat[75:12];
   assign w_live = dat[75:12];
   assign flag_in = dat[11:7];
   assign pri_in = dat[6:4];
   assign dsp_a = {ev[10], dat[3:2]};
   assign dsp_b = {ev[11], dat[1:0]};
   // One-cycle event, data inverted once it is over
   task automatic fire(input logic [11:0] e, input logic [75:0] d);
      @(posedge sys_clk);
      ev <= e;
      dat <= d;
      @(posedge sys_clk);
      ev <= '0;
      dat <= ~d;
   endtask : fire
endmodule : ccsr_pipe_model

// ==== dv/tb_ccsr_top.sv ====
// Self-checking bench of the mode and flag register block
module tb_ccsr_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************
   // Signals
   // ***********************************************
   logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic flag_upd, repeat_start, repeat_done, loop_start, loop_end;
   logic pri_load, trap_set, trap_clr, fast_save, fast_restore;
   ccsr_pkg::ccsr_alu_s flag_in, alu_flags;
   ccsr_pkg::ccsr_dsp_s dsp_a, dsp_b;
   ccsr_pkg::ccsr_loop_s loop_in, loop_ctx;
   ccsr_pkg::ccsr_wset_t w_live, w_restore;
   logic [2:0] pri_in, m_pri, m_dep;
   logic loop_early_stop, w_restore_valid, prog_window_enable;
   logic acc_a_clamp_enable, acc_b_clamp_enable, store_clamp_enable;
   logic acc_clamp_width_select, round_bias_select, mult_int_select;
   logic mult_sign_select, loop_active_flag, repeat_active_flag;
   logic [3:0] cpu_priority;
   logic [15:0] cpu_flags_register, core_configuration_register, m_cfg;
   logic [4:0] m_alu;
   logic m_trap, m_ra, m_oa, m_ob, m_sa, m_sb, m_es;
   logic [75:0] d, sv, c1;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed;
   // ***********************************************
   // Instances
   // ***********************************************
   ccsr_top uut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .flag_upd, .flag_in, .dsp_a, .dsp_b, .repeat_start, .repeat_done,
      .loop_start, .loop_end, .loop_in, .pri_load, .pri_in, .trap_set,
      .trap_clr, .fast_save, .fast_restore, .w_live, .loop_ctx,
      .loop_early_stop, .w_restore, .w_restore_valid, .prog_window_enable,
      .acc_a_clamp_enable, .acc_b_clamp_enable, .store_clamp_enable,
      .acc_clamp_width_select, .round_bias_select, .mult_int_select,
      .mult_sign_select, .cpu_priority, .alu_flags, .loop_active_flag,
      .repeat_active_flag, .cpu_flags_register,
      .core_configuration_register);
   ccsr_pipe_model pipe (.sys_clk, .flag_upd, .repeat_start, .repeat_done,
      .loop_start, .loop_end, .pri_load, .trap_set, .trap_clr, .fast_save,
      .fast_restore, .flag_in, .dsp_a, .dsp_b, .loop_in, .pri_in, .w_live);
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ***********************************************
   // Model and checks
   // ***********************************************
   function automatic logic [15:0] x_flags();
      return {m_oa, m_ob, m_sa, m_sb, m_oa | m_ob, m_sa | m_sb,
         m_dep != 3'h0, m_alu[4], m_pri, m_ra, m_alu[3:0]};
   endfunction : x_flags
   function automatic logic [15:0] x_cfg();
      return m_cfg | {5'h00, m_dep, 4'h0, m_trap, 3'h0};
   endfunction : x_cfg
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [15:0] wd, input logic [3:0] be);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, wd};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // Configuration write and its expected effect
   task automatic cfg_wr(input logic [15:0] wd, input logic [1:0] be);
      logic [15:0] m;
      m = 16'h10F7 & {{8{be[1]}}, {8{be[0]}}};
      bus(1'b1, 4'h4, wd, {2'b00, be});
      m_cfg = (m_cfg & ~m) | (wd & m);
      if (be[0] && !wd[3]) m_trap = 1'b0;
      if (be[1] && wd[11] && m_dep != 3'h0) m_es = 1'b1;
   endtask : cfg_wr
   // High byte flags write, bits 15..10 given, DC kept
   task automatic flags_hi(input logic [5:0] t);
      bus(1'b1, 4'h0, {t, 1'b0, m_alu[4], 8'h00}, 4'h2);
      if (!t[3] || !t[0]) m_sa = 1'b0;
      if (!t[2] || !t[0]) m_sb = 1'b0;
   endtask : flags_hi
   task automatic check_all();
      @(negedge sys_clk);
      check(cpu_flags_register, x_flags());
      check(core_configuration_register, x_cfg());
      check({mult_sign_select, acc_a_clamp_enable, acc_b_clamp_enable,
         store_clamp_enable, acc_clamp_width_select, prog_window_enable,
         round_bias_select, mult_int_select},
         {m_cfg[12], m_cfg[7:4], m_cfg[2:0]});
      check({cpu_priority, alu_flags, loop_active_flag, repeat_active_flag,
         loop_early_stop}, {m_trap, m_pri, m_alu, m_dep != 3'h0, m_ra,
         m_es});
      bus(1'b0, 4'h0, 16'h0000, 4'h3);
      check(q, {16'h0000, x_flags()});
      bus(1'b0, 4'h4, 16'h0000, 4'h3);
      check(q, {16'h0000, x_cfg()});
   endtask : check_all
   function automatic logic [75:0] rnd();
      return 76'({$random(seed), $random(seed), $random(seed)});
   endfunction : rnd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      seed = 32'hC480;
      {resetn, avs_read, avs_write} = 3'b000;
      {avs_address, avs_byteenable, avs_writedata} = '0;
      {m_alu, m_pri, m_dep, m_trap, m_ra, m_oa, m_ob, m_sa, m_sb} = '0;
      m_es = 1'b0;
      m_cfg = 16'h0020;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      check_all();
      $display("reset values done");
      for (int i = 0; i < 12; i++) begin
         cfg_wr(16'($random(seed)), 2'($random(seed)));
         check_all();
      end
      $display("configuration writes done");
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         pipe.fire(12'h001, d);
         m_alu = d[11:7];
         check_all();
      end
      $display("alu flags done");
      sv = rnd();
      pipe.fire(12'h001, sv);
      pipe.fire(12'h100, sv);
      d = rnd();
      pipe.fire(12'h001, d);
      m_alu = d[11:7];
      check_all();
      pipe.fire(12'h200, rnd());
      @(negedge sys_clk);
      check({w_restore_valid, w_restore}, {1'b1, sv[75:12]});
      m_alu = sv[11:7];
      check_all();
      check(w_restore_valid, 1'b0);
      $display("fast save and restore done");
      c1 = rnd();
      pipe.fire(12'h008, c1);
      d = rnd();
      pipe.fire(12'h008, d);
      m_dep = 3'h2;
      check_all();
      check(loop_ctx, d[75:12]);
      flags_hi(6'b001101);
      check_all();
      cfg_wr(m_cfg | 16'h0800, 2'b10);
      check_all();
      pipe.fire(12'h010, rnd());
      m_dep = 3'h1;
      m_es = 1'b0;
      check_all();
      check(loop_ctx, c1[75:12]);
      pipe.fire(12'h010, rnd());
      m_dep = 3'h0;
      check_all();
      $display("hardware loop done");
      d = rnd();
      d[3:0] = 4'b1101;
      pipe.fire(12'hC00, d);
      {m_oa, m_sa, m_ob, m_sb} = 4'b1101;
      check_all();
      d[3:0] = 4'b0000;
      pipe.fire(12'h400, d);
      m_oa = 1'b0;
      check_all();
      flags_hi(6'b001100);
      check_all();
      $display("accumulator status done");
      d = rnd();
      d[6:4] = 3'h5;
      pipe.fire(12'h020, d);
      m_pri = 3'h5;
      pipe.fire(12'h040, rnd());
      m_trap = 1'b1;
      check_all();
      pipe.fire(12'h080, rnd());
      m_trap = 1'b0;
      check_all();
      pipe.fire(12'h040, rnd());
      m_trap = 1'b1;
      cfg_wr(m_cfg, 2'b01);
      check_all();
      $display("priority done");
      pipe.fire(12'h002, rnd());
      m_ra = 1'b1;
      check_all();
      pipe.fire(12'h004, rnd());
      m_ra = 1'b0;
      check_all();
      bus(1'b1, 4'h8, 16'hFFFF, 4'h3);
      bus(1'b0, 4'h8, 16'h0000, 4'h3);
      check(q, 32'h0000_0000);
      check_all();
      $display("repeat and unmapped done");
      end_of_test();
   end
endmodule : tb_ccsr_top
